// >>> bdq_params.svh
// constants of the two-way queue and mailbox block: widths, depths, presets, counts.
// assumes inclusion by bare name from the package and the design modules.
`ifndef BDQ_PARAMS_SVH
`define BDQ_PARAMS_SVH

`define BDQ_DATA_W 36
`define BDQ_DEPTH 512
`define BDQ_OFS_W 9
`define BDQ_OFS_MIN 9'h001
`define BDQ_OFS_MAX 9'h1FC
`define BDQ_PRESET_BOTH 9'h040
`define BDQ_PRESET_HI 9'h010
`define BDQ_PRESET_LO 9'h008
`define BDQ_PROG_WRITES 3'h4
`define BDQ_PROG_FULL_AB 3'h0
`define BDQ_PROG_EMPTY_AB 3'h1
`define BDQ_PROG_FULL_BA 3'h2
`define BDQ_PROG_EMPTY_BA 3'h3
`define BDQ_RESET_EDGES 4

`endif

// >>> bdq_pkg.sv
// types shared by the queue block: port control carrier, flag carrier, top state.
// assumes bdq_params.svh on the include path.
`include "bdq_params.svh"

package bdq_pkg;

    typedef struct packed {
        logic select_n;
        logic direction;
        logic enable;
        logic mail_sel;
    } bdq_port_ctrl_type;

    typedef struct packed {
        logic space_ready;
        logic word_ready;
        logic near_empty_n;
        logic near_full_n;
    } bdq_flags_type;

    typedef struct packed {
        logic [`BDQ_DATA_W-1:0] mail_ab_reg;
        logic [`BDQ_DATA_W-1:0] mail_ba_reg;
        logic mail_ab_full_n;
        logic mail_ba_full_n;
        logic reset_ab_prev;
        logic reset_ba_prev;
        logic prog_active;
        logic [2:0] prog_count;
        logic [`BDQ_OFS_W-1:0] full_offset_ab;
        logic [`BDQ_OFS_W-1:0] empty_offset_ab;
        logic [`BDQ_OFS_W-1:0] full_offset_ba;
        logic [`BDQ_OFS_W-1:0] empty_offset_ba;
    } bdq_top_state_type;

endpackage : bdq_pkg

// >>> bdq_queue.sv
// one clocked queue with output register, ready flags and near-empty/near-full flags.
// assumes one clock; the reader and writer stall on the ready/valid outputs.
`timescale 1ns/10ps
`include "bdq_params.svh"

module bdq_queue
    import bdq_pkg::*;
#(
    parameter int WIDTH = `BDQ_DATA_W,
    parameter int DEPTH = `BDQ_DEPTH,
    parameter int OFS_W = `BDQ_OFS_W
)
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic hold_i,
    input wire logic write_valid_i,
    output logic write_ready_o,
    input wire logic [WIDTH-1:0] write_data_i,
    input wire logic read_ready_i,
    output logic read_valid_o,
    output logic [WIDTH-1:0] read_data_o,
    input wire logic [OFS_W-1:0] empty_offset_i,
    input wire logic [OFS_W-1:0] full_offset_i,
    output logic near_empty_n_o,
    output logic near_full_n_o
);

    localparam int AW = $clog2(DEPTH);

    if ((DEPTH != (1 << AW)) || (AW + 1 <= OFS_W) || (WIDTH < OFS_W))
    begin : g_bad_params
        $error("bdq_queue: depth must be a power of two and hold the offset range");
    end

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
        logic [AW:0] wptr_s1;
        logic [AW:0] wptr_s2;
        logic [AW:0] rptr_s1;
        logic started;
        logic space_ready;
        logic word_ready;
        logic near_empty_n;
        logic near_full_n;
        logic [WIDTH-1:0] out_data;
    } bdq_queue_state_type;

    localparam bdq_queue_state_type ST_RESET = '{near_full_n: 1'b1, default: '0};

    bdq_queue_state_type st_reg;
    bdq_queue_state_type st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_write;
    logic [AW:0] read_level;
    logic [AW:0] empty_ofs_w;
    logic [AW:0] full_limit;

    assign empty_ofs_w = {{(AW + 1 - OFS_W){1'b0}}, empty_offset_i};
    assign full_limit = (AW + 1)'(DEPTH) - {{(AW + 1 - OFS_W){1'b0}}, full_offset_i};

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next = st_reg;
        do_write = write_valid_i && st_reg.space_ready && !clear_i;
        read_level = st_reg.wptr_s2 - st_reg.rptr;
        if (do_write)
        begin
            st_next.wptr = st_reg.wptr + 1'b1;
        end
        // two stage delay of the write pointer sets the third-edge word latency
        st_next.wptr_s1 = st_reg.wptr;
        st_next.wptr_s2 = st_reg.wptr_s1;
        st_next.rptr_s1 = st_reg.rptr;
        if ((read_level != '0) && (!st_reg.word_ready || read_ready_i))
        begin
            st_next.out_data = mem[st_reg.rptr[AW-1:0]];
            st_next.rptr = st_reg.rptr + 1'b1;
            st_next.word_ready = 1'b1;
        end
        else if (read_ready_i)
        begin
            st_next.word_ready = 1'b0;
        end
        st_next.started = 1'b1;
        // freed space is seen through one delayed pointer, so the flag lags a read by two edges
        st_next.space_ready = st_reg.started && !hold_i &&
            ((st_next.wptr - st_reg.rptr_s1) != (AW + 1)'(DEPTH));
        st_next.near_empty_n = (st_next.wptr_s2 - st_next.rptr) > empty_ofs_w;
        st_next.near_full_n = (st_next.wptr - st_next.rptr_s1) < full_limit;
        if (clear_i)
        begin
            st_next = ST_RESET;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (do_write)
        begin
            mem[st_reg.wptr[AW-1:0]] <= write_data_i;
        end
    end

    assign write_ready_o = st_reg.space_ready;
    assign read_valid_o = st_reg.word_ready;
    assign read_data_o = st_reg.out_data;
    assign near_empty_n_o = st_reg.near_empty_n;
    assign near_full_n_o = st_reg.near_full_n;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_write_to_empty;
        do_write && (st_reg.wptr == st_reg.rptr) && !st_reg.word_ready;
    endsequence

    a_word_third_edge: assert property (@(posedge clock_i) disable iff (!reset_n_i || clear_i)
        s_write_to_empty |=> !read_valid_o [*3] ##1 read_valid_o)
    else $error("word ready did not rise on the third edge after a write to empty");

    a_output_held: assert property (@(posedge clock_i) disable iff (!reset_n_i || clear_i)
        read_valid_o && !read_ready_i |=> $stable(read_data_o) && read_valid_o)
    else $error("output register moved without a read");

endmodule : bdq_queue

// >>> bdq_top.sv
// two-way queue block with mailboxes, offset presets and port-A offset programming.
// assumes both ports and all reset pins synchronous to clock_i; data pins split in/out/enable.
`timescale 1ns/10ps
`include "bdq_params.svh"

// Notes on behaviour
// - queue reset clears pointers, flags, mailbox flag
// - space-ready rises two edges after reset release
// - offset selects captured when queue reset rises
// - any select high loads preset 64/16/8
// - four offset registers steer the near flags
// - first four A writes load offsets, not data
// - offset from nine low A lines, 1..508
// - after programming, B space-ready rises, normal run
// - A lines driven only selected and reading
// - enabled A write with space loads queue_a_to_b
// - enabled A read with word advances queue_b_to_a
// - A mail write, mail output, mail read clears
// - port B mirrors A, direction inverted
// - enabled B write with space loads queue_b_to_a
// - enabled B read with word advances queue_a_to_b
// - B mail write, mail output, mail read clears
// - both ports operate independently
// - empty output register loads itself automatically
// - output register advances only on enabled read
// - full mailbox ignores writes until read
// - word-ready rises third edge after write
// - near-empty low at or below offset
module bdq_top
    import bdq_pkg::*;
#(
    parameter int DEPTH = `BDQ_DEPTH
)
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic reset_ab_n_i,
    input wire logic reset_ba_n_i,
    input wire logic offset_sel_lo_i,
    input wire logic offset_sel_hi_i,
    input wire bdq_port_ctrl_type port_a_ctrl_i,
    input wire logic [`BDQ_DATA_W-1:0] port_a_bus_i,
    output logic [`BDQ_DATA_W-1:0] port_a_bus_o,
    output logic port_a_bus_oe_n_o,
    output bdq_flags_type port_a_flags_o,
    input wire bdq_port_ctrl_type port_b_ctrl_i,
    input wire logic [`BDQ_DATA_W-1:0] port_b_bus_i,
    output logic [`BDQ_DATA_W-1:0] port_b_bus_o,
    output logic port_b_bus_oe_n_o,
    output bdq_flags_type port_b_flags_o,
    output logic mail_ab_full_n_o,
    output logic mail_ba_full_n_o
);

    localparam bdq_top_state_type ST_RESET = '{
        mail_ab_full_n: 1'b1,
        mail_ba_full_n: 1'b1,
        full_offset_ab: `BDQ_PRESET_LO,
        empty_offset_ab: `BDQ_PRESET_LO,
        full_offset_ba: `BDQ_PRESET_LO,
        empty_offset_ba: `BDQ_PRESET_LO,
        default: '0
    };

    if (DEPTH <= `BDQ_OFS_MAX)
    begin : g_bad_depth
        $error("bdq_top: depth too small for the offset range");
    end

    bdq_top_state_type st_reg;
    bdq_top_state_type st_next;

    logic a_active;
    logic a_write;
    logic a_read;
    logic b_active;
    logic b_write;
    logic b_read;
    logic ab_write_valid;
    logic ab_read_ready;
    logic ba_write_valid;
    logic ba_read_ready;
    logic prog_write;
    logic [`BDQ_OFS_W-1:0] prog_value;
    logic ab_released;
    logic ba_released;
    logic [1:0] offset_sel;
    logic [`BDQ_DATA_W-1:0] ab_out_data;
    logic [`BDQ_DATA_W-1:0] ba_out_data;
    logic [`BDQ_OFS_W-1:0] preset_value;
    logic mail_a_write;
    logic mail_a_read;
    logic mail_b_write;
    logic mail_b_read;

    ////////////////////////////////////////////////////////////////////////////
    // port decode; each port only looks at its own pins
    assign a_active = !port_a_ctrl_i.select_n && port_a_ctrl_i.enable;
    assign a_write = a_active && port_a_ctrl_i.direction;
    assign a_read = a_active && !port_a_ctrl_i.direction;
    assign b_active = !port_b_ctrl_i.select_n && port_b_ctrl_i.enable;
    assign b_write = b_active && !port_b_ctrl_i.direction;
    assign b_read = b_active && port_b_ctrl_i.direction;

    assign ab_write_valid = a_write && !port_a_ctrl_i.mail_sel && !st_reg.prog_active;
    assign prog_write = a_write && !port_a_ctrl_i.mail_sel && st_reg.prog_active &&
        port_a_flags_o.space_ready;
    assign ba_read_ready = a_read && !port_a_ctrl_i.mail_sel;
    assign ba_write_valid = b_write && !port_b_ctrl_i.mail_sel;
    assign ab_read_ready = b_read && !port_b_ctrl_i.mail_sel;

    assign mail_a_write = a_write && port_a_ctrl_i.mail_sel;
    assign mail_a_read = a_read && port_a_ctrl_i.mail_sel;
    assign mail_b_write = b_write && port_b_ctrl_i.mail_sel;
    assign mail_b_read = b_read && port_b_ctrl_i.mail_sel;

    assign prog_value = port_a_bus_i[`BDQ_OFS_W-1:0];
    assign ab_released = reset_ab_n_i && !st_reg.reset_ab_prev;
    assign ba_released = reset_ba_n_i && !st_reg.reset_ba_prev;
    assign offset_sel = {offset_sel_hi_i, offset_sel_lo_i};

    always_comb
    begin
        unique case (offset_sel)
            2'b11: preset_value = `BDQ_PRESET_BOTH;
            2'b10: preset_value = `BDQ_PRESET_HI;
            2'b01: preset_value = `BDQ_PRESET_LO;
            2'b00: preset_value = `BDQ_PRESET_LO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next = st_reg;
        st_next.reset_ab_prev = reset_ab_n_i;
        st_next.reset_ba_prev = reset_ba_n_i;

        // offset choice is made on the release edge of each queue reset
        if (ab_released)
        begin
            if (offset_sel != 2'b00)
            begin
                st_next.full_offset_ab = preset_value;
                st_next.empty_offset_ab = preset_value;
            end
            else
            begin
                st_next.prog_active = 1'b1;
                st_next.prog_count = 3'h0;
            end
        end
        if (ba_released)
        begin
            if (offset_sel != 2'b00)
            begin
                st_next.full_offset_ba = preset_value;
                st_next.empty_offset_ba = preset_value;
            end
            else
            begin
                st_next.prog_active = 1'b1;
                st_next.prog_count = 3'h0;
            end
        end

        if (prog_write)
        begin
            unique case (st_reg.prog_count)
                `BDQ_PROG_FULL_AB: st_next.full_offset_ab = prog_value;
                `BDQ_PROG_EMPTY_AB: st_next.empty_offset_ab = prog_value;
                `BDQ_PROG_FULL_BA: st_next.full_offset_ba = prog_value;
                default: st_next.empty_offset_ba = prog_value;
            endcase
            st_next.prog_count = st_reg.prog_count + 3'h1;
            if (st_reg.prog_count + 3'h1 == `BDQ_PROG_WRITES)
            begin
                st_next.prog_active = 1'b0;
            end
        end

        // a mail write beats a same-cycle read only when the mailbox was empty; a write to a full mailbox is dropped even as it is read
        if (mail_b_read)
        begin
            st_next.mail_ab_full_n = 1'b1;
        end
        if (mail_a_write && st_reg.mail_ab_full_n)
        begin
            st_next.mail_ab_reg = port_a_bus_i;
            st_next.mail_ab_full_n = 1'b0;
        end
        if (mail_a_read)
        begin
            st_next.mail_ba_full_n = 1'b1;
        end
        if (mail_b_write && st_reg.mail_ba_full_n)
        begin
            st_next.mail_ba_reg = port_b_bus_i;
            st_next.mail_ba_full_n = 1'b0;
        end

        if (!reset_ab_n_i)
        begin
            st_next.mail_ab_full_n = 1'b1;
        end
        if (!reset_ba_n_i)
        begin
            st_next.mail_ba_full_n = 1'b1;
        end
        // a preset release after programming began cancels the unfinished sequence
        if ((ab_released || ba_released) && (offset_sel != 2'b00))
        begin
            st_next.prog_active = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // queue_a_to_b: written from A, read from B
    bdq_queue #(
        .WIDTH(`BDQ_DATA_W),
        .DEPTH(DEPTH),
        .OFS_W(`BDQ_OFS_W)
    ) u_queue_a_to_b (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clear_i(!reset_ab_n_i),
        .hold_i(1'b0),
        .write_valid_i(ab_write_valid),
        .write_ready_o(port_a_flags_o.space_ready),
        .write_data_i(port_a_bus_i),
        .read_ready_i(ab_read_ready),
        .read_valid_o(port_b_flags_o.word_ready),
        .read_data_o(ab_out_data),
        .empty_offset_i(st_reg.empty_offset_ab),
        .full_offset_i(st_reg.full_offset_ab),
        .near_empty_n_o(port_b_flags_o.near_empty_n),
        .near_full_n_o(port_a_flags_o.near_full_n)
    );

    // queue_b_to_a: written from B, read from A; B space held off while offsets are programmed
    bdq_queue #(
        .WIDTH(`BDQ_DATA_W),
        .DEPTH(DEPTH),
        .OFS_W(`BDQ_OFS_W)
    ) u_queue_b_to_a (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clear_i(!reset_ba_n_i),
        .hold_i(st_reg.prog_active),
        .write_valid_i(ba_write_valid),
        .write_ready_o(port_b_flags_o.space_ready),
        .write_data_i(port_b_bus_i),
        .read_ready_i(ba_read_ready),
        .read_valid_o(port_a_flags_o.word_ready),
        .read_data_o(ba_out_data),
        .empty_offset_i(st_reg.empty_offset_ba),
        .full_offset_i(st_reg.full_offset_ba),
        .near_empty_n_o(port_a_flags_o.near_empty_n),
        .near_full_n_o(port_b_flags_o.near_full_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // drive control ignores enable and clock, only select and direction count
    assign port_a_bus_oe_n_o = !(!port_a_ctrl_i.select_n && !port_a_ctrl_i.direction);
    assign port_a_bus_o = port_a_ctrl_i.mail_sel ? st_reg.mail_ba_reg : ba_out_data;
    assign port_b_bus_oe_n_o = !(!port_b_ctrl_i.select_n && port_b_ctrl_i.direction);
    assign port_b_bus_o = port_b_ctrl_i.mail_sel ? st_reg.mail_ab_reg : ab_out_data;
    assign mail_ab_full_n_o = st_reg.mail_ab_full_n;
    assign mail_ba_full_n_o = st_reg.mail_ba_full_n;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_ab_release;
        $rose(reset_ab_n_i) ##1 reset_ab_n_i;
    endsequence

    a_space_after_reset: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        s_ab_release |-> !port_a_flags_o.space_ready ##1 port_a_flags_o.space_ready)
    else $error("port A space ready not raised two edges after reset");

    a_reset_flags: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !reset_ab_n_i |=> !port_a_flags_o.space_ready && !port_b_flags_o.word_ready &&
            !port_b_flags_o.near_empty_n && port_a_flags_o.near_full_n && mail_ab_full_n_o)
    else $error("queue reset left a flag in the wrong state");

    a_preset_both: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ab_released && offset_sel_hi_i && offset_sel_lo_i |=>
            st_reg.empty_offset_ab == `BDQ_PRESET_BOTH && st_reg.full_offset_ab == `BDQ_PRESET_BOTH)
    else $error("preset offset not loaded");

    a_prog_no_store: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        st_reg.prog_active && reset_ab_n_i |=> $stable(u_queue_a_to_b.st_reg.wptr))
    else $error("queue written while offsets are programmed");

    a_prog_first: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        prog_write && st_reg.prog_count == 3'h0 |=> st_reg.full_offset_ab == $past(port_a_bus_i[8:0]))
    else $error("first programming write did not load the A-to-B full offset");

    a_prog_b_held: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        st_reg.prog_active |=> !port_b_flags_o.space_ready)
    else $error("port B space ready raised during programming");

    a_mail_ab_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mail_a_write && mail_ab_full_n_o && reset_ab_n_i |=>
            !mail_ab_full_n_o && st_reg.mail_ab_reg == $past(port_a_bus_i))
    else $error("mail write to empty mailbox not stored");

    a_mail_ab_blocked: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !mail_ab_full_n_o && mail_a_write |=> $stable(st_reg.mail_ab_reg))
    else $error("full mailbox overwritten");

    a_mail_b_read: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mail_b_read && !mail_a_write |=> mail_ab_full_n_o)
    else $error("mailbox flag not set by port B read");

    a_a_drive_mail: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !port_a_bus_oe_n_o && port_a_ctrl_i.mail_sel |-> port_a_bus_o == st_reg.mail_ba_reg &&
            !port_a_ctrl_i.select_n && !port_a_ctrl_i.direction)
    else $error("port A drives wrong data or while not reading");

    a_b_drive_mail: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !port_b_bus_oe_n_o && port_b_ctrl_i.mail_sel |-> port_b_bus_o == st_reg.mail_ab_reg &&
            !port_b_ctrl_i.select_n && port_b_ctrl_i.direction)
    else $error("port B drives wrong data or while not reading");

    a_mail_ba_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        mail_b_write && mail_ba_full_n_o && reset_ba_n_i |=>
            !mail_ba_full_n_o && st_reg.mail_ba_reg == $past(port_b_bus_i))
    else $error("mail write to empty port B mailbox not stored");

    a_mail_ba_blocked: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !mail_ba_full_n_o && mail_b_write |=> $stable(st_reg.mail_ba_reg))
    else $error("full port B mailbox overwritten");

endmodule : bdq_top

// >>> bdq_port_host.sv
// far-side host of one port: drives control levels and write data.
// assumes one calling process per port, requests launched on rising edges.
`timescale 1ns/10ps
`include "bdq_params.svh"

module bdq_port_host
    import bdq_pkg::*;
(
    input wire logic clock_i,
    output bdq_port_ctrl_type ctrl_o,
    output logic [`BDQ_DATA_W-1:0] bus_o
);
    initial
    begin
        ctrl_o = bdq_port_ctrl_type'(4'h8);
        bus_o = '0;
    end

    ////////////////////////////////////////
    // one request per call, held until the edge that takes it
    task op(input logic [3:0] c, input logic [`BDQ_DATA_W-1:0] d);
        @(posedge clock_i);
        ctrl_o <= bdq_port_ctrl_type'(c);
        bus_o <= d;
    endtask : op

    // released lines show the inverse so stale data never looks valid
    task idle();
        @(posedge clock_i);
        ctrl_o <= bdq_port_ctrl_type'(4'h8);
        bus_o <= ~bus_o;
    endtask : idle
endmodule : bdq_port_host

// >>> tb_bdq_top.sv
// bench of the two-way queue block: stream, mailbox, drive and offset tests.
// assumes one clock for both ports; queue models are plain queues.
`timescale 1ns/10ps
`include "bdq_params.svh"

module tb_bdq_top
    import bdq_pkg::*;
;
    localparam int W = `BDQ_DATA_W;
    logic clock_i, reset_n_i, reset_ab_n, reset_ba_n, sel_lo, sel_hi;
    bdq_port_ctrl_type a_ctrl, b_ctrl;
    logic [W-1:0] a_out, b_out, a_drv, b_drv;
    logic a_oe_n, b_oe_n, mab_n, mba_n;
    bdq_flags_type fa, fb;
    int errors, n_checks, seed, cyc;
    logic [W-1:0] q_ab[$], q_ba[$];

    bdq_port_host i_host_a(.clock_i(clock_i), .ctrl_o(a_ctrl), .bus_o(a_drv));
    bdq_port_host i_host_b(.clock_i(clock_i), .ctrl_o(b_ctrl), .bus_o(b_drv));
    bdq_top #(.DEPTH(512)) i_bdq_top(.clock_i(clock_i), .reset_n_i(reset_n_i),
        .reset_ab_n_i(reset_ab_n), .reset_ba_n_i(reset_ba_n), .offset_sel_lo_i(sel_lo),
        .offset_sel_hi_i(sel_hi), .port_a_ctrl_i(a_ctrl), .port_a_bus_i(a_oe_n ? a_drv : a_out),
        .port_a_bus_o(a_out), .port_a_bus_oe_n_o(a_oe_n), .port_a_flags_o(fa),
        .port_b_ctrl_i(b_ctrl), .port_b_bus_i(b_oe_n ? b_drv : b_out), .port_b_bus_o(b_out),
        .port_b_bus_oe_n_o(b_oe_n), .port_b_flags_o(fb), .mail_ab_full_n_o(mab_n),
        .mail_ba_full_n_o(mba_n));

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [W-1:0] e, input logic [W-1:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask : chk

    task automatic hop(input bit b, input logic [3:0] c, input logic [W-1:0] d);
        if (b)
            i_host_b.op(c, d);
        else
            i_host_a.op(c, d);
    endtask : hop

    task automatic hidle(input bit b);
        if (b)
            i_host_b.idle();
        else
            i_host_a.idle();
    endtask : hidle

    task automatic qreset(input logic hi, input logic lo, input logic b_ok);
        @(posedge clock_i);
        reset_ab_n <= 1'b0;
        reset_ba_n <= 1'b0;
        sel_hi <= hi;
        sel_lo <= lo;
        repeat (5) @(posedge clock_i);
        @(negedge clock_i);
        chk("flags_a", 4'h1, fa);
        chk("flags_b", 4'h1, fb);
        chk("mail_flags", 2'h3, {mab_n, mba_n});
        @(posedge clock_i);
        reset_ab_n <= 1'b1;
        reset_ba_n <= 1'b1;
        repeat (2) @(negedge clock_i);
        chk("space_a_early", 1'b0, fa.space_ready);
        @(negedge clock_i);
        chk("space_a", 1'b1, fa.space_ready);
        chk("space_b", b_ok, fb.space_ready);
        q_ab.delete();
        q_ba.delete();
    endtask : qreset

    // b selects the B port as writer
    task automatic push(input bit b, input int n);
        logic [63:0] r;
        for (int i = 0; i < n; i++)
        begin
            r = {$random(seed), $random(seed)};
            if (b)
                q_ba.push_back(r[W-1:0]);
            else
                q_ab.push_back(r[W-1:0]);
            hop(b, b ? 4'h2 : 4'h6, r[W-1:0]);
        end
        hidle(b);
    endtask : push

    // b selects the B port as reader; a disabled read goes first and must not advance
    task automatic drain(input bit b, input int n);
        for (int i = 0; i < n; i++)
        begin
            for (int k = 0; k < 20 && (b ? fb.word_ready : fa.word_ready) !== 1'b1; k++)
                @(negedge clock_i);
            if (b)
                chk("b_data", q_ab.pop_front(), b_out);
            else
                chk("a_data", q_ba.pop_front(), a_out);
            hop(b, b ? 4'h4 : 4'h0, '0);
            hop(b, b ? 4'h6 : 4'h2, '0);
            hidle(b);
            @(negedge clock_i);
        end
    endtask : drain

    // b=0: A to B mailbox; the second write must be ignored
    task automatic mail(input bit b);
        logic [W-1:0] d;
        d = {$random(seed), 4'hA};
        hop(b, b ? 4'h3 : 4'h7, d);
        hop(b, b ? 4'h3 : 4'h7, ~d);
        hidle(b);
        @(negedge clock_i);
        chk("mail_full", 1'b0, b ? mba_n : mab_n);
        hop(!b, b ? 4'h3 : 4'h7, '0);
        @(negedge clock_i);
        chk("mail_data", d, b ? a_out : b_out);
        hidle(!b);
        @(negedge clock_i);
        chk("mail_free", 1'b1, b ? mba_n : mab_n);
        hop(b, b ? 4'h3 : 4'h7, ~d);
        hidle(b);
        @(negedge clock_i);
        chk("mail_refill", 1'b0, b ? mba_n : mab_n);
    endtask : mail

    // preset seen through the near-empty threshold of queue_a_to_b
    task automatic preset_run(input logic hi, input logic lo, input int x);
        qreset(hi, lo, 1'b1);
        push(0, x + 1);
        repeat (8) @(negedge clock_i);
        chk("near_empty_at", 1'b0, fb.near_empty_n);
        push(0, 1);
        repeat (8) @(negedge clock_i);
        chk("near_empty_over", 1'b1, fb.near_empty_n);
    endtask : preset_run

    task conclude();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            conclude();
        end
    end

    initial
    begin
        seed = 34;
        errors = 0;
        n_checks = 0;
        cyc = 0;
        reset_n_i = 1'b0;
        reset_ab_n = 1'b0;
        reset_ba_n = 1'b0;
        sel_lo = 1'b0;
        sel_hi = 1'b0;
        repeat (5) @(posedge clock_i);
        reset_n_i <= 1'b1;
        qreset(1'b1, 1'b0, 1'b1);
        fork
            push(0, 17);
            push(1, 3);
        join
        repeat (8) @(negedge clock_i);
        chk("near_empty_16", 1'b0, fb.near_empty_n);
        push(0, 1);
        repeat (8) @(negedge clock_i);
        chk("near_empty_17", 1'b1, fb.near_empty_n);
        drain(1, 18);
        drain(0, 3);
        $display("stream test done");
        mail(0);
        mail(1);
        $display("mailbox test done");
        for (int i = 0; i < 8; i++)
        begin
            hop(i[2], {i[1:0], 2'h0}, '0);
            @(negedge clock_i);
            chk("oe_n", {i[1:0]} != {1'b0, i[2]}, i[2] ? b_oe_n : a_oe_n);
        end
        hidle(0);
        hidle(1);
        $display("drive test done");
        qreset(1'b0, 1'b0, 1'b0);
        hop(0, 4'h6, {27'h0, 9'h1FC});
        hop(0, 4'h6, {27'h0, 9'h003});
        hop(0, 4'h6, {27'h0, 9'h001});
        hidle(0);
        @(negedge clock_i);
        chk("space_b_prog", 1'b0, fb.space_ready);
        hop(0, 4'h6, {27'h0, 9'h002});
        hidle(0);
        repeat (2) @(negedge clock_i);
        chk("space_b_done", 1'b1, fb.space_ready);
        push(0, 5);
        push(1, 4);
        repeat (8) @(negedge clock_i);
        chk("near_full_a", 1'b0, fa.near_full_n);
        chk("near_empty_b", 1'b1, fb.near_empty_n);
        chk("near_empty_a", 1'b1, fa.near_empty_n);
        chk("near_full_b", 1'b1, fb.near_full_n);
        drain(1, 5);
        drain(0, 4);
        $display("offset programming test done");
        preset_run(1'b1, 1'b1, 64);
        preset_run(1'b0, 1'b1, 8);
        $display("preset test done");
        conclude();
    end
endmodule : tb_bdq_top
